/* File: testbench/pin_source.sv */
`timescale 1ns/1ps

// ****************************************************************
// Far-side clock and gate pins
// ****************************************************************
module pin_source (
   input  wire logic core_clk,
   output logic      lowerExtClk,
   output logic      upperExtClk,
   output logic      lowerGate,
   output logic      upperGate
);
   // Pins rest low; the clock only moves inside a burst
   initial begin
      lowerExtClk = 1'b0;
      upperExtClk = 1'b0;
      lowerGate   = 1'b0;
      upperGate   = 1'b0;
   end

   // Two cycles high, three low, so every rising edge is seen by the sampler
   // Only the selected pin moves, so the other half must stay put
   task automatic burst(input bit up, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         if (up) begin
            upperExtClk <= 1'b1;
         end else begin
            lowerExtClk <= 1'b1;
         end
         repeat (2) @(posedge core_clk);
         lowerExtClk <= 1'b0;
         upperExtClk <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask

   // Gate held high for len cycles, then a falling edge
   task automatic gatePulse(input bit up, input int len);
      @(posedge core_clk);
      if (up) begin
         upperGate <= 1'b1;
      end else begin
         lowerGate <= 1'b1;
      end
      repeat (len) @(posedge core_clk);
      lowerGate <= 1'b0;
      upperGate <= 1'b0;
   endtask
endmodule // pin_source

/* File: testbench/tb.sv */
`timescale 1ns/1ps

// ****************************************************************
// Register-level tests of the paired timer
// ****************************************************************
module tb;
   logic        core_clk;
   logic        rst;
   logic [5:0]  wbAdr;
   logic [31:0] wbDat;
   logic [31:0] wbDatO;
   logic [31:0] q;
   logic [3:0]  wbSel;
   logic        wbWe;
   logic        wbCyc;
   logic        wbStb;
   logic        wbAck;
   logic        idleMode;
   logic        irq;
   logic        adcTrig;
   logic        lowerExtClk;
   logic        upperExtClk;
   logic        lowerGate;
   logic        upperGate;
   int          badCount;
   int          nTests;
   int          g;

   pin_source src (.core_clk(core_clk), .lowerExtClk(lowerExtClk),
      .upperExtClk(upperExtClk), .lowerGate(lowerGate), .upperGate(upperGate));

   paired_timer_control dut (.core_clk(core_clk), .rst(rst), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDat), .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_stb_i(wbStb),
      .wb_cyc_i(wbCyc), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .lowerExtClk(lowerExtClk), .upperExtClk(upperExtClk), .lowerGate(lowerGate),
      .upperGate(upperGate), .idleMode(idleMode), .irq(irq), .adcTrig(adcTrig));

   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;

   task automatic endOfTest();
      if (badCount == 0 && nTests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One classic cycle; the slave's latency is not assumed, the watchdog bounds it
   task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      wbAdr <= a;
      wbWe  <= w;
      wbDat <= d;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      do @(posedge core_clk); while (wbAck !== 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(q, exp);
   endtask

   // Cycles between two conversion-trigger pulses, skipping a partial first period
   task automatic trigGap(output int gap);
      do @(posedge core_clk); while (adcTrig !== 1'b1);
      gap = 0;
      do begin
         @(posedge core_clk);
         gap++;
      end while (adcTrig !== 1'b1);
   endtask

   // Bounds a hang well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      badCount++;
      endOfTest();
   end

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {wbAdr, wbDat, wbWe, wbCyc, wbStb, idleMode} = '0;
      wbSel = 4'hF;
      badCount = 0;
      nTests = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rdChk(6'h00, 32'h0000);
      rdChk(6'h10, 32'hFFFF);
      wr(6'h00, 32'hFFFF);
      rdChk(6'h00, 32'hA07A);
      wr(6'h04, 32'hFFFF);
      rdChk(6'h04, 32'hA072);
      wr(6'h00, 32'h0);
      wr(6'h04, 32'h0);
      rdChk(6'h20, 32'h0);
      // Upper half alone through every prescale code: gap is (period+1)*ratio
      wr(6'h14, 32'h3);
      wr(6'h1C, 32'h2);
      for (int c = 0; c < 4; c++) begin
         wr(6'h04, 32'h8000 | (c << 4));
         trigGap(g);
         check(g, (c == 3) ? 32'h400 : 32'(4 << (3 * c)));
      end
      wr(6'h04, 32'h0);
      check(irq, 1'b1);
      wr(6'h1C, 32'h0);
      repeat (2) @(posedge core_clk);
      check(irq, 1'b0);
      wr(6'h18, 32'h2);
      rdChk(6'h18, 32'h0);
      // Pair mode: upper controls stopped and slow, yet the pair runs at 1:1
      wr(6'h14, 32'h0);
      wr(6'h0C, 32'h0);
      wr(6'h10, 32'h5);
      wr(6'h04, 32'h0030);
      wr(6'h00, 32'h8008);
      trigGap(g);
      check(g, 6);
      wr(6'h00, 32'h0);
      rdChk(6'h18, 32'h2);
      wr(6'h18, 32'h3);
      // Carry from the low word into the high word
      wr(6'h08, 32'hFFFF);
      wr(6'h0C, 32'h0);
      wr(6'h10, 32'hFFFF);
      wr(6'h14, 32'h1);
      wr(6'h00, 32'h8008);
      wr(6'h00, 32'h0008);
      rdChk(6'h0C, 32'h1);
      // External clock counts edges while the gate enable is ignored
      wr(6'h08, 32'h0);
      wr(6'h00, 32'h8042);
      src.burst(1'b0, 5);
      rdChk(6'h08, 32'h5);
      // Upper half on its own pin; the quiet lower pin leaves its count alone
      wr(6'h14, 32'hFFFF);
      wr(6'h0C, 32'h0);
      wr(6'h04, 32'h8002);
      src.burst(1'b1, 3);
      rdChk(6'h0C, 32'h3);
      rdChk(6'h08, 32'h5);
      wr(6'h04, 32'h0);
      // Gated internal clock: no count with gate low, event on its fall
      wr(6'h00, 32'h0);
      wr(6'h08, 32'h0);
      wr(6'h18, 32'h3);
      wr(6'h00, 32'h8040);
      rdChk(6'h08, 32'h0);
      src.gatePulse(1'b0, 10);
      repeat (3) @(posedge core_clk);
      rdChk(6'h18, 32'h1);
      // Upper gate fall lands on the upper flag in 16-bit mode
      wr(6'h04, 32'h8040);
      src.gatePulse(1'b1, 10);
      repeat (3) @(posedge core_clk);
      rdChk(6'h18, 32'h3);
      wr(6'h04, 32'h0);
      // Idle halt freezes the count; without it the count moves on
      wr(6'h00, 32'h0);
      wr(6'h08, 32'h0);
      idleMode <= 1'b1;
      wr(6'h00, 32'hA000);
      repeat (10) @(posedge core_clk);
      rdChk(6'h08, 32'h0);
      wr(6'h00, 32'h8000);
      xfer(6'h08, 1'b0, 32'h0);
      check({31'h0, q !== 32'h0}, 32'h1);
      idleMode <= 1'b0;
      endOfTest();
   end
endmodule // tb

/* File: verilog/paired_timer_control.sv */
`timescale 1ns/1ps
`include "paired_timer_map.svh"


module paired_timer_control (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_cyc_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        lowerExtClk,
   input  wire logic        upperExtClk,
   input  wire logic        lowerGate,
   input  wire logic        upperGate,
   input  wire logic        idleMode,
   output logic             irq,
   output logic             adcTrig
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   paired_timer_pkg::wb_req_t     req;
   paired_timer_pkg::timer_ctrl_t lowerCtrl;
   paired_timer_pkg::timer_ctrl_t upperCtrl;

   logic [15:0] lowerCtl_q;
   logic [15:0] upperCtl_q;
   logic [15:0] lowerCount_q;
   logic [15:0] upperCount_q;
   logic [15:0] lowerPeriod_q;
   logic [15:0] upperPeriod_q;
   logic [1:0]  status_q;
   logic [1:0]  mask_q;
   logic [1:0]  statusSet;
   logic [1:0]  statusClr;
   logic        ack_q;
   logic        irq_q;
   logic        adcTrig_q;
   logic [31:0] rdat_q;
   logic [31:0] rdMux;
   logic [15:0] lanes;
   logic        access;
   logic        wrEn;
   logic        pairMode;
   logic        clrLower;
   logic        clrUpper;
   logic        lowerTick;
   logic        upperTick;
   logic        lowerGateFall;
   logic        upperGateFall;
   logic [31:0] pairCount;
   logic [31:0] pairPeriod;
   logic [31:0] pairNext;
   logic        pairAtPeriod;
   logic        pairMatch;
   logic        lowerMatch;
   logic        upperMatch;
   logic        wrLowerCnt;
   logic        wrUpperCnt;

   // Write merge on byte lanes 0 and 1, limited to implemented bits
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] data,
      input logic [15:0] laneMask,
      input logic [15:0] impl
   );
      merge = (old & ~(laneMask & impl)) | (data & laneMask & impl);
   endfunction

   // Control register to effective control fields
   function automatic paired_timer_pkg::timer_ctrl_t toCtrl(input logic [15:0] r);
      toCtrl = '{run:      r[`BIT_RUN],
                 idleHalt: r[`BIT_IDLE],
                 gateEn:   r[`BIT_GATE],
                 presc:    r[`BIT_PSHI:`BIT_PSLO],
                 clkSel:   r[`BIT_CSEL]};
   endfunction

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   // Word aligned address; low address bits are not decoded
   assign req    = '{adr: {wb_adr_i[5:2], 2'h0},
                     dat: wb_dat_i,
                     sel: wb_sel_i,
                     we:  wb_we_i};
   assign access = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wrEn   = access & req.we;
   assign lanes  = {{8{req.sel[1]}}, {8{req.sel[0]}}};
   assign wrLowerCnt = wrEn && (req.adr == `ADR_LCNT);
   assign wrUpperCnt = wrEn && (req.adr == `ADR_UCNT);

   // One wait state; the ack drops after a single cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      case (req.adr)
         `ADR_LCTL: rdMux = {16'h0000, lowerCtl_q};
         `ADR_UCTL: rdMux = {16'h0000, upperCtl_q};
         `ADR_LCNT: rdMux = {16'h0000, lowerCount_q};
         `ADR_UCNT: rdMux = {16'h0000, upperCount_q};
         `ADR_LPER: rdMux = {16'h0000, lowerPeriod_q};
         `ADR_UPER: rdMux = {16'h0000, upperPeriod_q};
         `ADR_STAT: rdMux = {30'h00000000, status_q};
         `ADR_MASK: rdMux = {30'h00000000, mask_q};
         default:   rdMux = 32'h00000000;
      endcase
   end

   // Read data is held until the next read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdat_q <= 32'h00000000;
      end else if (access && !req.we) begin
         rdat_q <= rdMux;
      end
   end

   // ****************************************************************
   // Control and period registers
   // ****************************************************************
   // Only implemented bits store, so reserved bits always read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lowerCtl_q <= `CTL_RESET;
         upperCtl_q <= `CTL_RESET;
      end else if (wrEn && req.adr == `ADR_LCTL) begin
         lowerCtl_q <= merge(lowerCtl_q, req.dat[15:0], lanes, `LCTL_IMPL);
      end else if (wrEn && req.adr == `ADR_UCTL) begin
         upperCtl_q <= merge(upperCtl_q, req.dat[15:0], lanes, `UCTL_IMPL);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lowerPeriod_q <= `PER_RESET;
         upperPeriod_q <= `PER_RESET;
      end else if (wrEn && req.adr == `ADR_LPER) begin
         lowerPeriod_q <= merge(lowerPeriod_q, req.dat[15:0], lanes, `FULL_MASK);
      end else if (wrEn && req.adr == `ADR_UPER) begin
         upperPeriod_q <= merge(upperPeriod_q, req.dat[15:0], lanes, `FULL_MASK);
      end
   end

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   assign pairMode  = lowerCtl_q[`BIT_PAIR];
   assign lowerCtrl = toCtrl(lowerCtl_q);
   // Upper controls are forced off while paired
   assign upperCtrl = pairMode ? '0 : toCtrl(upperCtl_q);

   // Rewriting a running timer's control restarts its prescaler
   assign clrLower = wrEn && (req.adr == `ADR_LCTL) && lowerCtrl.run;
   assign clrUpper = wrEn && (req.adr == `ADR_UCTL) && upperCtrl.run;

   // Lower prescaler also clocks the pair
   timer_prescale #(
      .PRESC_W (8)
   ) u_lower (
      .core_clk (core_clk),
      .rst      (rst),
      .ctrl     (lowerCtrl),
      .extClk   (lowerExtClk),
      .gate     (lowerGate),
      .idleMode (idleMode),
      .clrPresc (clrLower),
      .tick     (lowerTick),
      .gateFall (lowerGateFall)
   );

   // Upper prescaler with its own pin and controls in 16-bit mode
   timer_prescale #(
      .PRESC_W (8)
   ) u_upper (
      .core_clk (core_clk),
      .rst      (rst),
      .ctrl     (upperCtrl),
      .extClk   (upperExtClk),
      .gate     (upperGate),
      .idleMode (idleMode),
      .clrPresc (clrUpper),
      .tick     (upperTick),
      .gateFall (upperGateFall)
   );

   // ****************************************************************
   // Count and match
   // ****************************************************************
   assign pairCount    = {upperCount_q, lowerCount_q};
   assign pairPeriod   = {upperPeriod_q, lowerPeriod_q};
   assign pairAtPeriod = (pairCount == pairPeriod);
   assign pairNext     = pairAtPeriod ? 32'h00000000 : pairCount + 32'h00000001;
   assign pairMatch    = pairMode & lowerTick & pairAtPeriod;
   assign lowerMatch   = ~pairMode & lowerTick & (lowerCount_q == lowerPeriod_q);
   assign upperMatch   = ~pairMode & upperTick & (upperCount_q == upperPeriod_q);

   // Lower count; a software write wins over a tick
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lowerCount_q <= `CNT_RESET;
      end else if (wrLowerCnt) begin
         lowerCount_q <= merge(lowerCount_q, req.dat[15:0], lanes, `FULL_MASK);
      end else if (lowerTick && pairMode) begin
         lowerCount_q <= pairNext[15:0];
      end else if (lowerTick) begin
         lowerCount_q <= lowerMatch ? `CNT_RESET : lowerCount_q + 16'h0001;
      end
   end

   // Upper count follows the pair carry, or its own ticks
   always_ff @(posedge core_clk) begin
      if (rst) begin
         upperCount_q <= `CNT_RESET;
      end else if (wrUpperCnt) begin
         upperCount_q <= merge(upperCount_q, req.dat[15:0], lanes, `FULL_MASK);
      end else if (lowerTick && pairMode) begin
         upperCount_q <= pairNext[31:16];
      end else if (upperTick) begin
         upperCount_q <= upperMatch ? `CNT_RESET : upperCount_q + 16'h0001;
      end
   end

   // ****************************************************************
   // Interrupt status, mask and trigger
   // ****************************************************************
   // Paired events land on the upper flag
   always_comb begin
      statusSet = 2'h0;
      statusSet[`ST_LOWER] = lowerMatch | (~pairMode & lowerGateFall);
      statusSet[`ST_UPPER] = upperMatch | pairMatch | upperGateFall
                           | (pairMode & lowerGateFall);
   end

   assign statusClr = (wrEn && req.adr == `ADR_STAT && req.sel[0])
                      ? req.dat[1:0] : 2'h0;

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_q <= `ST_RESET;
      end else begin
         status_q <= (status_q & ~statusClr) | statusSet;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mask_q <= `ST_RESET;
      end else if (wrEn && req.adr == `ADR_MASK && req.sel[0]) begin
         mask_q <= req.dat[1:0];
      end
   end

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // The lower half of a split pair never triggers conversion
   always_ff @(posedge core_clk) begin
      if (rst) begin
         adcTrig_q <= 1'b0;
      end else begin
         adcTrig_q <= upperMatch | pairMatch;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign irq      = irq_q;
   assign adcTrig  = adcTrig_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_stop_holds_count: assert property (
      (!lowerCtrl.run && !wrLowerCnt) |=> $stable(lowerCount_q))
      else $error("lower count moved while stopped");

   a_idle_halts_count: assert property (
      (lowerCtrl.idleHalt && idleMode && !wrLowerCnt) |=> $stable(lowerCount_q))
      else $error("lower count moved in idle with halt set");

   a_upper_ignored: assert property (
      pairMode |-> !upperTick)
      else $error("upper timer ticked in pair mode");

   a_pair_carry: assert property (
      (pairMode && lowerTick && lowerCount_q == `FULL_MASK && !pairAtPeriod
       && !wrLowerCnt && !wrUpperCnt)
      |=> (upperCount_q == $past(upperCount_q) + 16'h0001) && (lowerCount_q == `CNT_RESET))
      else $error("pair carry into upper word lost");

   a_pair_period_split: assert property (
      (lowerCount_q == lowerPeriod_q && upperCount_q != upperPeriod_q) |-> !pairMatch)
      else $error("pair matched on low word alone");

   a_pair_match_flag: assert property (
      (pairMatch && !wrLowerCnt && !wrUpperCnt)
      |=> status_q[`ST_UPPER] && pairCount == 32'h00000000 ##1 irq_q || !mask_q[`ST_UPPER])
      else $error("pair match did not wrap and raise upper flag");

   a_lower_no_trigger: assert property (
      (lowerMatch && !upperMatch) |=> !adcTrig_q)
      else $error("lower 16-bit match triggered conversion");

   a_wrap_sixteen: assert property (
      (lowerMatch && !wrLowerCnt) |=> (lowerCount_q == `CNT_RESET) && status_q[`ST_LOWER])
      else $error("16-bit period match did not wrap and flag");

   a_reserved_zero: assert property (
      (access && !req.we && (req.adr == `ADR_LCTL || req.adr == `ADR_UCTL))
      |=> wb_ack_o && ((wb_dat_o & `RSV_MASK) == 32'h00000000))
      else $error("reserved control bits read nonzero");

   c_pair_match:  cover property (pairMatch ##1 adcTrig_q);
   c_upper_match: cover property (upperMatch ##1 adcTrig_q);
   c_gate_fall:   cover property (lowerGateFall);
   c_irq:         cover property (irq_q);

endmodule // paired_timer_control

/* File: verilog/paired_timer_map.svh */
`ifndef PAIRED_TIMER_MAP_SVH
`define PAIRED_TIMER_MAP_SVH

// ****************************************************************
// Register byte addresses on the bus
// ****************************************************************
`define ADR_LCTL     6'h00
`define ADR_UCTL     6'h04
`define ADR_LCNT     6'h08
`define ADR_UCNT     6'h0C
`define ADR_LPER     6'h10
`define ADR_UPER     6'h14
`define ADR_STAT     6'h18
`define ADR_MASK     6'h1C

// ****************************************************************
// Control register field positions
// ****************************************************************
`define BIT_RUN      15
`define BIT_IDLE     13
`define BIT_GATE     6
`define BIT_PSHI     5
`define BIT_PSLO     4
`define BIT_PAIR     3
`define BIT_CSEL     1

// Implemented bits of each control register
`define LCTL_IMPL    16'hA07A
`define UCTL_IMPL    16'hA072
`define FULL_MASK    16'hFFFF
`define RSV_MASK     32'h00005F80

// ****************************************************************
// Reset values
// ****************************************************************
`define CTL_RESET    16'h0000
`define CNT_RESET    16'h0000
`define PER_RESET    16'hFFFF
`define ST_RESET     2'h0

// ****************************************************************
// Prescale codes and terminal counts (divide by 1, 8, 64, 256)
// ****************************************************************
`define PS_DIV1      2'h0
`define PS_DIV8      2'h1
`define PS_DIV64     2'h2
`define PS_DIV256    2'h3
`define PS_TERM1     8'h00
`define PS_TERM8     8'h07
`define PS_TERM64    8'h3F
`define PS_TERM256   8'hFF

// Status and mask bit positions
`define ST_LOWER     0
`define ST_UPPER     1

`endif

/* File: verilog/paired_timer_pkg.sv */
package paired_timer_pkg;

   // Effective controls of one timer half
   typedef struct packed {
      logic       run;
      logic       idleHalt;
      logic       gateEn;
      logic [1:0] presc;
      logic       clkSel;
   } timer_ctrl_t;

   // One bus request as the slave sees it
   typedef struct packed {
      logic [5:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
   } wb_req_t;

endpackage

/* File: verilog/timer_prescale.sv */
`timescale 1ns/1ps
`include "paired_timer_map.svh"

module timer_prescale #(
   parameter int PRESC_W = 8
) (
   input  wire logic                         core_clk,
   input  wire logic                         rst,
   input  wire paired_timer_pkg::timer_ctrl_t ctrl,
   input  wire logic                         extClk,
   input  wire logic                         gate,
   input  wire logic                         idleMode,
   input  wire logic                         clrPresc,
   output logic                              tick,
   output logic                              gateFall
);

   // ****************************************************************
   // Edge detection on the pins
   // ****************************************************************
   logic               extPrev_q;
   logic               gatePrev_q;
   logic [PRESC_W-1:0] cnt_q;
   logic [PRESC_W-1:0] term;
   logic               active;
   logic               gated;
   logic               extRise;
   logic               evt;

   // Pins are already synchronous, so one stage of history is enough
   always_ff @(posedge core_clk) begin
      if (rst) begin
         extPrev_q  <= 1'b0;
         gatePrev_q <= 1'b0;
      end else begin
         extPrev_q  <= extClk;
         gatePrev_q <= gate;
      end
   end

   // ****************************************************************
   // Input event selection
   // ****************************************************************
   assign active  = ctrl.run & ~(ctrl.idleHalt & idleMode);
   assign gated   = ctrl.gateEn & ~ctrl.clkSel;
   assign extRise = extClk & ~extPrev_q;
   assign evt     = active & (ctrl.clkSel ? extRise : (~gated | gate));
   assign gateFall = active & gated & gatePrev_q & ~gate;

   // Terminal count of the prescaler
   always_comb begin
      case (ctrl.presc)
         `PS_DIV1:  term = PRESC_W'(`PS_TERM1);
         `PS_DIV8:  term = PRESC_W'(`PS_TERM8);
         `PS_DIV64: term = PRESC_W'(`PS_TERM64);
         default:   term = PRESC_W'(`PS_TERM256);
      endcase
   end

   // At-or-above compare: a lowered ratio cannot strand the count
   assign tick = evt & (cnt_q >= term);

   // Prescale counter; a control write while running restarts it
   always_ff @(posedge core_clk) begin
      if (rst || clrPresc) begin
         cnt_q <= '0;
      end else if (evt) begin
         cnt_q <= tick ? '0 : cnt_q + PRESC_W'(1);
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_presc_one: assert property (
      (active && !ctrl.clkSel && !ctrl.gateEn && ctrl.presc == `PS_DIV1) |-> tick)
      else $error("divide by one did not tick");
   a_presc_eight: assert property (
      (tick && ctrl.presc == `PS_DIV8) |=> (!tick || ctrl.presc != `PS_DIV8)[*7])
      else $error("divide by eight ticked early");
   a_ext_no_gate: assert property (
      (active && ctrl.clkSel && extRise && ctrl.presc == `PS_DIV1) |-> tick)
      else $error("external edge lost to gate");
   a_ext_edge_only: assert property (
      (ctrl.clkSel && !extRise) |-> !tick)
      else $error("external clock ticked without rising edge");
   a_gate_low_hold: assert property (
      (gated && !gate) |-> !tick)
      else $error("gated timer counted with gate low");
   a_presc_clear: assert property (
      clrPresc |=> (cnt_q == '0))
      else $error("prescaler not cleared by control write");

endmodule // timer_prescale
